// ===== bench/bhc_chk.sv
// Port-level assertions for the Hall commutation block
module bhc_chk import bhc_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
    input  wire logic core_clk_i,
    input  wire logic reset_i,
    input  wire logic main_supply_ok_i,
    input  wire logic sleep_request_low_i,
    input  wire logic brake_request_low_i,
    input  wire logic rotor_sensor_a_i,
    input  wire logic rotor_sensor_b_i,
    input  wire logic rotor_sensor_c_i,
    input  wire logic gate_supply_enable_o,
    input  wire logic upper_gate_a_o,
    input  wire logic upper_gate_b_o,
    input  wire logic upper_gate_c_o,
    input  wire logic lower_gate_a_o,
    input  wire logic lower_gate_b_o,
    input  wire logic lower_gate_c_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (reset_i);

    ////////////////////////////////////////////////////////////////////////
    // Helper logic
    logic        any_up;
    logic        any_gate;
    logic        bad_hall;
    logic [15:0] up_cnt_r;

    // Summaries of the gate pins and the Hall code
    assign any_up   = upper_gate_a_o | upper_gate_b_o | upper_gate_c_o;
    assign any_gate = any_up | lower_gate_a_o | lower_gate_b_o | lower_gate_c_o;
    assign bad_hall = (rotor_sensor_a_i == rotor_sensor_b_i)
                      && (rotor_sensor_b_i == rotor_sensor_c_i) && brake_request_low_i;

    // Awake cycles with gate supply on
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i || !gate_supply_enable_o || !sleep_request_low_i || !main_supply_ok_i)
            up_cnt_r <= '0;
        else if (up_cnt_r != 16'hFFFF)
            up_cnt_r <= up_cnt_r + 16'h0001;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    gate_overlap_a : assert property (
        !(upper_gate_a_o && lower_gate_a_o) && !(upper_gate_b_o && lower_gate_b_o)
        && !(upper_gate_c_o && lower_gate_c_o))
        else $error("upper and lower gate on together");
    upper_dead_a : assert property (
        $rose(upper_gate_a_o) |-> !$past(lower_gate_a_o) && !$past(lower_gate_a_o, 2))
        else $error("phase a upper on without dead time");
    lower_dead_a : assert property (
        $rose(lower_gate_b_o) |-> !$past(upper_gate_b_o) && !$past(upper_gate_b_o, 2))
        else $error("phase b lower on without dead time");
    sleep_off_a : assert property (
        (!sleep_request_low_i)[*8] |-> !any_gate)
        else $error("gates on while asleep");
    supply_off_a : assert property (
        (!main_supply_ok_i)[*8] |-> !any_gate && !gate_supply_enable_o)
        else $error("active without main supply");
    enable_cause_a : assert property (
        $rose(gate_supply_enable_o) |->
            $past(main_supply_ok_i, 3) && $past(sleep_request_low_i, 3))
        else $error("gate supply enabled without cause");
    powerup_wait_a : assert property (
        $rose(any_gate) |-> up_cnt_r >= 16'(POWERUP_CYCLES))
        else $error("gates driven before power-up done");
    brake_upper_a : assert property (
        (!brake_request_low_i)[*8] |-> !any_up)
        else $error("upper gate on while braking");
    bad_hall_a : assert property (
        bad_hall[*8] |-> !any_gate)
        else $error("gates on with invalid Hall code");

    // Main scenarios reached
    run_seen_c   : cover property ($rose(any_gate));
    brake_seen_c : cover property ((!brake_request_low_i)[*8] ##1 lower_gate_c_o);
    sleep_seen_c : cover property ($fell(sleep_request_low_i) ##8 !any_gate);
endmodule : bhc_chk

bind bhc_top bhc_chk #(.POWERUP_CYCLES(POWERUP_CYCLES)) u_chk (
    .core_clk_i, .reset_i, .main_supply_ok_i, .sleep_request_low_i, .brake_request_low_i,
    .rotor_sensor_a_i, .rotor_sensor_b_i, .rotor_sensor_c_i, .gate_supply_enable_o,
    .upper_gate_a_o, .upper_gate_b_o, .upper_gate_c_o,
    .lower_gate_a_o, .lower_gate_b_o, .lower_gate_c_o);

// ===== bench/bhc_far_model.sv
// Far-side model: gate supply that ramps after enable, and the rotor sensors
module bhc_far_model
(
    input  wire logic       core_clk_i,
    input  wire logic       enable_i,
    input  wire logic       slow_i,
    input  wire logic [2:0] hall_i,
    output logic            supply_ok_o,
    output logic            sensor_a_o,
    output logic            sensor_b_o,
    output logic            sensor_c_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [5:0] ramp_r;

    // Supply charges for a while after enable, collapses at once when cut
    always_ff @(posedge core_clk_i)
    begin
        if (!enable_i)
            ramp_r <= '0;
        else if (ramp_r != 6'h3F)
            ramp_r <= ramp_r + 6'h01;
    end
    assign supply_ok_o = ramp_r >= (slow_i ? 6'h28 : 6'h02);

    // Push-pull sensors, so the pin always shows the rotor code
    assign {sensor_a_o, sensor_b_o, sensor_c_o} = hall_i;
endmodule : bhc_far_model

// ===== bench/bhc_top_tb.sv
// Self-checking bench for the Hall commutation block
module bhc_top_tb import bhc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int PUP = 20;
    logic        core_clk_i, reset_i, main_ok, sleep_low, brake_low, pwm, dir, slow;
    logic        gs_en, gs_ok, ha, hb, hc, ua, ub, uc, la, lb, lc, wr, rd, gsmp, rd1;
    logic [2:0]  hall;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, rv;
    logic [6:0]  q_gt[$];
    logic [31:0] q_rd[$];
    logic [2:0]  seq[6] = '{3'b101, 3'b100, 3'b110, 3'b010, 3'b011, 3'b001};
    int          err_total, cmp_count, cyc;

    bhc_top #(.POWERUP_CYCLES(PUP)) uut (
        .core_clk_i, .reset_i, .main_supply_ok_i(main_ok),
        .gate_supply_ok_i(gs_ok), .gate_supply_enable_o(gs_en), .sleep_request_low_i(sleep_low),
        .brake_request_low_i(brake_low), .pwm_i(pwm), .dir_i(dir), .rotor_sensor_a_i(ha),
        .rotor_sensor_b_i(hb), .rotor_sensor_c_i(hc), .upper_gate_a_o(ua), .upper_gate_b_o(ub),
        .upper_gate_c_o(uc), .lower_gate_a_o(la), .lower_gate_b_o(lb), .lower_gate_c_o(lc),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
        .reg_rdata_o(rdata));
    bhc_far_model u_far (.core_clk_i, .enable_i(gs_en), .slow_i(slow),
        .hall_i(hall), .supply_ok_o(gs_ok), .sensor_a_o(ha), .sensor_b_o(hb), .sensor_c_o(hc));

    ////////////////////////////////////////////////////////////////////////
    // Clock, result monitor and hang guard
    initial
    begin
        core_clk_i = 1'b0;
        forever #50 core_clk_i = ~core_clk_i;
    end

    // Each result is compared with the oldest pending note
    always @(posedge core_clk_i)
    begin
        rd1 <= rd;
        cyc <= cyc + 1;
        if (gsmp) check("gates", 32'(q_gt.pop_front()), {25'h0, gs_en, ua, ub, uc, la, lb, lc});
        if (rd1) check("rdata", q_rd.pop_front(), rdata);
        if (cyc == 20000)
        begin
            err_total++;
            complete_run();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Tasks
    task automatic check(input string nm, input logic [31:0] e, s);
        cmp_count++;
        if (s !== e)
        begin
            err_total++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask : check

    // Pins change just after an edge
    task automatic step(input logic [2:0] h, input logic d, p, b);
        @(posedge core_clk_i);
        {hall, dir, pwm, brake_low} <= {h, d, p, b};
    endtask : step

    // Note the gate pattern due n cycles on and flag its sampling
    task automatic expect_g(input int n, input logic [6:0] e);
        repeat (n) @(posedge core_clk_i);
        q_gt.push_back(e);
        gsmp <= 1'b1;
        @(posedge core_clk_i);
        gsmp <= 1'b0;
    endtask : expect_g

    // One-cycle write, or read with d as the expected data
    task automatic reg_op(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk_i);
        {wr, rd, addr, wdata} <= {w, !w, a, d};
        if (!w) q_rd.push_back(d);
        @(posedge core_clk_i);
        {wr, rd} <= 2'b00;
    endtask : reg_op

    // Gate pattern {enable, upper a b c, lower a b c} while running
    function automatic logic [6:0] want(input logic [2:0] h, input logic d, p, b);
        logic [1:0] hi, lo;
        logic [6:0] g;
        g = 7'h40;
        case (h)
            3'b101: {hi, lo} = {PH_A, PH_C};
            3'b100: {hi, lo} = {PH_B, PH_C};
            3'b110: {hi, lo} = {PH_B, PH_A};
            3'b010: {hi, lo} = {PH_C, PH_A};
            3'b011: {hi, lo} = {PH_C, PH_B};
            3'b001: {hi, lo} = {PH_A, PH_B};
            default: return g;
        endcase
        if (!d) {hi, lo} = {lo, hi};
        if (!b) return 7'h47;
        g[5 - hi] = p;
        g[2 - hi] = !p;
        g[2 - lo] = 1'b1;
        return g;
    endfunction : want

    task automatic complete_run();
        $display("Totals: %0d compares, %0d mismatches", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run

    ////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        {reset_i, main_ok, sleep_low, brake_low, pwm, dir, slow} = 7'h5F;
        {hall, wr, rd, addr, wdata, gsmp} = {3'b101, 43'h0};
        void'($urandom(72885));
        repeat (3) @(posedge core_clk_i);
        reset_i <= 1'b0;
        // Nothing starts until the main supply, then the slow gate supply
        expect_g(20, 7'h00);
        main_ok <= 1'b1;
        expect_g(30, 7'h40);
        expect_g(PUP + 60, want(3'b101, 1'b1, 1'b1, 1'b1));
        $display("power-up test done");
        // Register reset values, unmapped and read-only places, clamp
        reg_op(0, REG_DEAD_TIME, 32'(DEAD_TIME_RST));
        reg_op(0, REG_RECHARGE_TIME, 32'(RECHARGE_TIME_RST));
        reg_op(0, 8'h0C, 32'h0);
        reg_op(1, REG_STATUS, 32'hFFFF_FFFF);
        reg_op(0, REG_STATUS, 32'(ST_RUN) | 32'h5 << ST_HALL_LSB | 32'h1 << ST_UPPER_LSB
                              | 32'h4 << ST_LOWER_LSB);
        reg_op(1, REG_DEAD_TIME, 32'h0);
        reg_op(0, REG_DEAD_TIME, 32'(DEAD_TIME_MIN));
        reg_op(1, REG_DEAD_TIME, 32'h3);
        reg_op(0, REG_DEAD_TIME, 32'h3);
        $display("register test done");
        // Every valid Hall code in both directions at both PWM levels
        for (int k = 0; k < 24; k++)
        begin
            step(seq[k % 6], 1'(k / 12), 1'(k / 6), 1'b1);
            expect_g(30, want(seq[k % 6], 1'(k / 12), 1'(k / 6), 1'b1));
        end
        $display("commutation test done");
        // Same phase stays PWM with PWM high, yet pulses low first
        reg_op(1, REG_DEAD_TIME, 32'h1);
        step(3'b101, 1'b1, 1'b1, 1'b1);
        expect_g(11, 7'h45);
        expect_g(20, want(3'b101, 1'b1, 1'b1, 1'b1));
        $display("recharge test done");
        // Random codes, including invalid ones and braking
        for (int k = 0; k < 40; k++)
        begin
            rv = $urandom;
            if (rv[2:0] inside {3'b000, 3'b111}) rv[6] = 1'b1;
            step(rv[2:0], rv[3], rv[4], rv[5] | rv[6]);
            expect_g(30, want(rv[2:0], rv[3], rv[4], rv[5] | rv[6]));
        end
        $display("random test done");
        // Asleep, brake and Hall changes are ignored; wake reruns power-up
        slow <= 1'b0;
        sleep_low <= 1'b0;
        step(3'b100, 1'b1, 1'b1, 1'b0);
        expect_g(20, 7'h00);
        step(3'b100, 1'b1, 1'b1, 1'b1);
        sleep_low <= 1'b1;
        expect_g(15, 7'h40);
        expect_g(40, want(3'b100, 1'b1, 1'b1, 1'b1));
        main_ok <= 1'b0;
        expect_g(20, 7'h00);
        $display("sleep test done");
        complete_run();
    end
endmodule : bhc_top_tb

// ===== verilog/bhc_dead_time.sv
// One half-bridge gate pair with break-before-make dead time
module bhc_dead_time import bhc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic       want_upper_i,
    input  wire logic       want_lower_i,
    input  wire logic [7:0] dead_cyc_i,
    output logic            upper_o,
    output logic            lower_o
);

    logic [7:0] cnt_r;

    ////////////////////////////////////////////////////////////////////////
    // Turn-off is immediate; turn-on waits out the dead count
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            upper_o <= 1'b0;
            lower_o <= 1'b0;
            cnt_r   <= 8'h00;
        end
        else if ((upper_o && !want_upper_i) || (lower_o && !want_lower_i))
        begin
            upper_o <= upper_o & want_upper_i;
            lower_o <= lower_o & want_lower_i;
            cnt_r   <= dead_cyc_i; // [RULE14]
        end
        else if (cnt_r != 8'h00)
            cnt_r <= cnt_r - 8'h01;
        else
        begin
            // Never both on, even if asked
            upper_o <= want_upper_i & ~lower_o; // [RULE14]
            lower_o <= want_lower_i & ~upper_o & ~want_upper_i;
        end
    end

endmodule : bhc_dead_time

// ===== verilog/bhc_pkg.sv
// Shared constants and types for the Hall commutation block
package bhc_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and timing
    localparam int CLK_PERIOD_NS    = 100;
    localparam int DEAD_MIN_NS      = 30;
    localparam int POWERUP_MIN_MS   = 1;
    localparam int RECHARGE_TIME_NS = 1000;

    // Least times round up to whole cycles
    localparam int DEAD_MIN_CYC = (DEAD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int POWERUP_CYC  = (POWERUP_MIN_MS * 1000000 + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;
    localparam int RECHARGE_CYC = (RECHARGE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    ////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] REG_DEAD_TIME     = 8'h00;
    localparam logic [7:0] REG_RECHARGE_TIME = 8'h04;
    localparam logic [7:0] REG_STATUS        = 8'h08;

    // Reset values of the writable registers, and the dead time floor
    localparam logic [7:0] DEAD_TIME_RST     = 8'(DEAD_MIN_CYC);
    localparam logic [7:0] RECHARGE_TIME_RST = 8'(RECHARGE_CYC);
    localparam logic [7:0] DEAD_TIME_MIN     = 8'(DEAD_MIN_CYC);

    // Status field positions
    localparam int ST_STATE_LSB = 0;
    localparam int ST_HALL_LSB  = 3;
    localparam int ST_UPPER_LSB = 6;
    localparam int ST_LOWER_LSB = 9;
    localparam int ST_RECHARGE  = 12;
    localparam int ST_BRAKE     = 13;
    localparam int ST_HALL_BAD  = 14;

    // Phase indices
    localparam logic [1:0] PH_A = 2'd0;
    localparam logic [1:0] PH_B = 2'd1;
    localparam logic [1:0] PH_C = 2'd2;

    // Sequencer states
    typedef enum logic [2:0] {
        ST_OFF       = 3'b000,
        ST_GATE_WAIT = 3'b001,
        ST_POWERUP   = 3'b010,
        ST_RUN       = 3'b011,
        ST_SLEEP     = 3'b100
    } bhc_state_t;

endpackage : bhc_pkg

// ===== verilog/bhc_sync.sv
// Three-stage input synchroniser with agreement filter
module bhc_sync import bhc_pkg::*;
(
    input  wire logic       core_clk_i,
    input  wire logic       reset_i,
    input  wire logic [8:0] pin_i,
    output logic      [8:0] level_o
);

    logic [8:0] s1_r;
    logic [8:0] s2_r;
    logic [8:0] s3_r;

    ////////////////////////////////////////////////////////////////////////
    // Stage one feeds only stage two; inputs idle low like their pulldowns
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
        end
        else
        begin
            s1_r <= pin_i;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // A change counts only once stages two and three agree
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            level_o <= '0; // [RULE13]
        else
            level_o <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_o);
    end

endmodule : bhc_sync

// ===== verilog/bhc_top.sv
// Hall commutation, brake, sleep and power-up sequencing for three half bridges
//
// Overview of operation
// [RULE1] Power-up starts only while the main supply is above its lockout level.
// [RULE2] Power-up enables the gate supply and waits for it to pass its threshold.
// [RULE3] Inputs act and gates drive only after a power-up wait of at least 1 ms.
// [RULE4] A low sleep request disables the block, holds gates off and ignores other inputs.
// [RULE5] The host must drive the sleep request high, since the pin idles low.
// [RULE6] Leaving sleep reruns the whole power-up sequence before gates drive again.
// [RULE7] A low brake request turns on all three lower gates regardless of PWM and Hall.
// [RULE8] Without braking the selected phase is driven high or low as PWM is.
// [RULE9] PWM phase gets upper=PWM, lower=not PWM; low phase lower on; floating phase off.
// [RULE10] Direction 1 maps Hall 101,100,110,010,011,001 to A/C,B/C,B/A,C/A,C/B,A/B.
// [RULE11] Direction 0 maps Hall 101,100,110,010,011,001 to C/A,C/B,A/B,A/C,B/C,B/A.
// [RULE12] Each Hall change first pulls the new PWM phase low for a recharge interval.
// [RULE13] Hall inputs idle low, so an open sensor input reads as 0.
// [RULE14] Each phase inserts a programmable dead interval of at least 30 ns.
// [RULE15] Hall states 000 and 111, sleep and incomplete power-up hold all gates off; a low brake request still turns the lower gates on for 000 and 111.
// [RULE16] Recharge and power-up waits are counters of configurable length.
module bhc_top import bhc_pkg::*;
#(
    parameter int POWERUP_CYCLES = POWERUP_CYC
)
(
    input  wire logic        core_clk_i,
    input  wire logic        reset_i,
    // Supply monitors and gate supply control
    input  wire logic        main_supply_ok_i,
    input  wire logic        gate_supply_ok_i,
    output logic             gate_supply_enable_o,
    // Host control pins
    input  wire logic        sleep_request_low_i,
    input  wire logic        brake_request_low_i,
    input  wire logic        pwm_i,
    input  wire logic        dir_i,
    // Motor position sensors
    input  wire logic        rotor_sensor_a_i,
    input  wire logic        rotor_sensor_b_i,
    input  wire logic        rotor_sensor_c_i,
    // Gate commands
    output logic             upper_gate_a_o,
    output logic             upper_gate_b_o,
    output logic             upper_gate_c_o,
    output logic             lower_gate_a_o,
    output logic             lower_gate_b_o,
    output logic             lower_gate_c_o,
    // Register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [8:0]  pins_raw;
    logic [8:0]  pins_sync;
    logic        main_ok;
    logic        gate_ok;
    logic        awake;
    logic        brake_low;
    logic        pwm;
    logic        dir;
    logic [2:0]  hall;

    bhc_state_t  state_r;
    bhc_state_t  state_nxt;
    logic [23:0] pwr_cnt_r;
    logic        pwr_done;

    logic [7:0]  dead_time_r;
    logic [7:0]  recharge_time_r;

    logic [2:0]  hall_prev_r;
    logic [7:0]  recharge_cnt_r;
    logic        recharge;
    logic        hall_moved;

    logic [4:0]  decode;
    logic        hall_ok;
    logic [1:0]  pwm_phase;
    logic [1:0]  low_phase;
    logic        running;

    logic [2:0]  want_upper;
    logic [2:0]  want_lower;
    logic [2:0]  upper;
    logic [2:0]  lower;

    ////////////////////////////////////////////////////////////////////////
    // Commutation decode: {valid, pwm phase, low phase}
    function automatic logic [4:0] commutate(input logic [2:0] h, input logic d);
        logic [4:0] r;
        r = 5'h00;
        if (d)
        begin
            case (h) // [RULE10]
                3'b101:  r = {1'b1, PH_A, PH_C};
                3'b100:  r = {1'b1, PH_B, PH_C};
                3'b110:  r = {1'b1, PH_B, PH_A};
                3'b010:  r = {1'b1, PH_C, PH_A};
                3'b011:  r = {1'b1, PH_C, PH_B};
                3'b001:  r = {1'b1, PH_A, PH_B};
                default: r = 5'h00; // [RULE15]
            endcase
        end
        else
        begin
            case (h) // [RULE11]
                3'b101:  r = {1'b1, PH_C, PH_A};
                3'b100:  r = {1'b1, PH_C, PH_B};
                3'b110:  r = {1'b1, PH_A, PH_B};
                3'b010:  r = {1'b1, PH_A, PH_C};
                3'b011:  r = {1'b1, PH_B, PH_C};
                3'b001:  r = {1'b1, PH_B, PH_A};
                default: r = 5'h00; // [RULE15]
            endcase
        end
        return r;
    endfunction : commutate

    ////////////////////////////////////////////////////////////////////////
    // All nine supply, host and sensor pins come from outside and pass the synchroniser
    assign pins_raw = {main_supply_ok_i, gate_supply_ok_i, sleep_request_low_i,
                       brake_request_low_i, pwm_i, dir_i,
                       rotor_sensor_a_i, rotor_sensor_b_i, rotor_sensor_c_i};

    bhc_sync u_sync (
        .core_clk_i (core_clk_i),
        .reset_i    (reset_i),
        .pin_i      (pins_raw),
        .level_o    (pins_sync)
    );

    // Sleep pin resets low, so an undriven pin keeps the block asleep
    assign main_ok   = pins_sync[8];
    assign gate_ok   = pins_sync[7];
    assign awake     = pins_sync[6]; // [RULE5]
    assign brake_low = pins_sync[5];
    assign pwm       = pins_sync[4];
    assign dir       = pins_sync[3];
    assign hall      = pins_sync[2:0];

    ////////////////////////////////////////////////////////////////////////
    // Power sequencer next state
    assign pwr_done = (pwr_cnt_r == 24'(POWERUP_CYCLES - 1));

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_OFF:
            begin
                if (main_ok && awake)
                    state_nxt = ST_GATE_WAIT; // [RULE1]
                else if (main_ok)
                    state_nxt = ST_SLEEP;
            end
            ST_GATE_WAIT:
            begin
                if (gate_ok)
                    state_nxt = ST_POWERUP; // [RULE2]
            end
            ST_POWERUP:
            begin
                if (!gate_ok)
                    state_nxt = ST_GATE_WAIT; // [RULE2]
                else if (pwr_done)
                    state_nxt = ST_RUN; // [RULE3]
            end
            ST_RUN:
                state_nxt = ST_RUN;
            ST_SLEEP:
            begin
                if (awake)
                    state_nxt = ST_GATE_WAIT; // [RULE6]
            end
            default:
                state_nxt = ST_OFF;
        endcase
        // Sleep overrides every state but supply loss
        if (!awake && state_r != ST_OFF)
            state_nxt = ST_SLEEP; // [RULE4]
        // Losing the main supply drops back to the start
        if (!main_ok)
            state_nxt = ST_OFF; // [RULE1]
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            state_r <= ST_OFF;
        else
            state_r <= state_nxt;
    end

    // Power-up wait counter, restarted on every entry
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            pwr_cnt_r <= 24'h00_0000;
        else if (state_r == ST_POWERUP && state_nxt == ST_POWERUP)
            pwr_cnt_r <= pwr_cnt_r + 24'h00_0001; // [RULE16]
        else
            pwr_cnt_r <= 24'h00_0000;
    end

    // Gate supply runs from power-up start until sleep or supply loss
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            gate_supply_enable_o <= 1'b0;
        else
            gate_supply_enable_o <= (state_nxt == ST_GATE_WAIT) ||
                                    (state_nxt == ST_POWERUP) ||
                                    (state_nxt == ST_RUN); // [RULE2]
    end

    assign running = (state_r == ST_RUN); // [RULE3]

    ////////////////////////////////////////////////////////////////////////
    // Recharge pulse on every Hall change while running
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            hall_prev_r <= 3'b000;
        else
            hall_prev_r <= hall;
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            recharge_cnt_r <= 8'h00;
        else if (!running)
            recharge_cnt_r <= 8'h00;
        else if (hall_moved)
            recharge_cnt_r <= recharge_time_r - 8'h01; // [RULE12]
        else if (recharge_cnt_r != 8'h00)
            recharge_cnt_r <= recharge_cnt_r - 8'h01; // [RULE16]
    end

    // Opens as the change shows, ahead of PWM; zero disables
    assign hall_moved = running && (hall != hall_prev_r) && (recharge_time_r != 8'h00);
    assign recharge   = hall_moved || (recharge_cnt_r != 8'h00);

    ////////////////////////////////////////////////////////////////////////
    // Gate demand per phase, before dead time
    assign decode    = commutate(hall, dir);
    assign hall_ok   = decode[4];
    assign pwm_phase = decode[3:2];
    assign low_phase = decode[1:0];

    always_comb
    begin
        want_upper = 3'b000;
        want_lower = 3'b000;
        if (!running)
        begin
            want_upper = 3'b000; // [RULE15]
            want_lower = 3'b000;
        end
        else if (!brake_low)
        begin
            want_lower = 3'b111; // [RULE7]
        end
        else if (hall_ok)
        begin
            // Recharge forces the PWM phase low even with PWM held high
            want_upper[pwm_phase] = pwm & ~recharge; // [RULE8] [RULE12]
            want_lower[pwm_phase] = ~pwm | recharge; // [RULE9] [RULE12]
            want_lower[low_phase] = 1'b1; // [RULE9]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // One dead-time stage per half bridge
    for (genvar p = 0; p < 3; p++)
    begin : g_phase
        bhc_dead_time u_dead (
            .core_clk_i   (core_clk_i),
            .reset_i      (reset_i),
            .want_upper_i (want_upper[p]),
            .want_lower_i (want_lower[p]),
            .dead_cyc_i   (dead_time_r),
            .upper_o      (upper[p]),
            .lower_o      (lower[p])
        );
    end

    assign upper_gate_a_o = upper[0];
    assign upper_gate_b_o = upper[1];
    assign upper_gate_c_o = upper[2];
    assign lower_gate_a_o = lower[0];
    assign lower_gate_b_o = lower[1];
    assign lower_gate_c_o = lower[2];

    ////////////////////////////////////////////////////////////////////////
    // Register writes; dead time clamps at the floor to keep shoot-through away
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            dead_time_r <= DEAD_TIME_RST;
        else if (reg_wr_i && reg_addr_i == REG_DEAD_TIME)
        begin
            if (reg_wdata_i[7:0] < DEAD_TIME_MIN)
                dead_time_r <= DEAD_TIME_MIN; // [RULE14]
            else
                dead_time_r <= reg_wdata_i[7:0];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            recharge_time_r <= RECHARGE_TIME_RST;
        else if (reg_wr_i && reg_addr_i == REG_RECHARGE_TIME)
            recharge_time_r <= reg_wdata_i[7:0]; // [RULE16]
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge core_clk_i)
    begin
        if (reset_i)
            reg_rdata_o <= 32'h0000_0000;
        else if (reg_rd_i)
        begin
            reg_rdata_o <= 32'h0000_0000;
            case (reg_addr_i)
                REG_DEAD_TIME:     reg_rdata_o[7:0] <= dead_time_r;
                REG_RECHARGE_TIME: reg_rdata_o[7:0] <= recharge_time_r;
                REG_STATUS:
                begin
                    reg_rdata_o[ST_STATE_LSB +: 3] <= state_r;
                    reg_rdata_o[ST_HALL_LSB +: 3]  <= hall;
                    reg_rdata_o[ST_UPPER_LSB +: 3] <= upper;
                    reg_rdata_o[ST_LOWER_LSB +: 3] <= lower;
                    reg_rdata_o[ST_RECHARGE]       <= recharge;
                    reg_rdata_o[ST_BRAKE]          <= running & ~brake_low;
                    reg_rdata_o[ST_HALL_BAD]       <= ~hall_ok;
                end
                default:           reg_rdata_o <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata_o <= 32'h0000_0000;
    end

endmodule : bhc_top
